// ===== core/fps_fan_source.sv
/*
 * Fan drive one: source binding, largest-request select, override,
 * polarity, throttle lock, and throttle-input duty measurement.
 * Assumes register accesses arrive already decoded from the management
 * bus, and zone duty requests come from the temperature lookup logic.
 */
// Function
// - Interval low nibble sets throttle-one period
// - Interval high nibble sets throttle-two period
// - Interval change mid-measure restarts that measurement
// - Source bits 0-3 bind zones one-four
// - Source bits 4-5 bind throttle inputs
// - Source bits 6-7 bind regulator hot inputs
// - Bound zones request duty via lookup
// - Bound hot inputs request duty via ramp
// - Largest bound request drives fan output
`timescale 1ns/1ns
module fps_fan_source #(
    parameter int SAMPLE_CYC = fps_pkg::SAMPLE_CYCLES,
    parameter int RAMP_CYC = fps_pkg::RAMP_CYCLES,
    parameter int PWM_TICK_CYC = fps_pkg::PWM_TICK_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [15:0] zone_duty_i,
    input wire logic cpu_throttle_pin_one_n_i,
    input wire logic cpu_throttle_pin_two_n_i,
    input wire logic regulator_hot_in_a_n_i,
    input wire logic regulator_hot_in_b_n_i,
    output logic fan_drive_out_one_o,
    output logic [7:0] throttle_measure_result_one_o,
    output logic [7:0] throttle_measure_result_two_o
);
    function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
        max4 = (a > b) ? a : b;
    endfunction

    function automatic logic [3:0] clamp_code(input logic [3:0] c);
        clamp_code = (c > fps_pkg::TI_CODE_MAX) ? fps_pkg::TI_CODE_MAX : c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [7:0] interval_reg, interval_next;
    logic [7:0] source_reg, source_next;
    logic ovr_en_reg, ovr_en_next;
    logic pol_reg, pol_next;
    logic lock_en_reg, lock_en_next;
    logic lock_act_reg, lock_act_next;
    logic [3:0] ovr_duty_reg, ovr_duty_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] duty_reg, duty_next;
    logic [3:0] duty_calc;
    logic [3:0] hot;
    logic bound_hot;
    logic bound_thr_event;
    logic wr_int, wr_src, wr_ovr;

    assign hot = {~regulator_hot_in_b_n_i, ~regulator_hot_in_a_n_i,
                  ~cpu_throttle_pin_two_n_i, ~cpu_throttle_pin_one_n_i};
    assign wr_int = reg_wr_i && (reg_addr_i == fps_pkg::ADDR_INTERVAL);
    assign wr_src = reg_wr_i && (reg_addr_i == fps_pkg::ADDR_SOURCE);
    assign wr_ovr = reg_wr_i && (reg_addr_i == fps_pkg::ADDR_OVERRIDE);
    assign bound_hot = |(hot & source_reg[7:fps_pkg::THR_LSB]);
    assign bound_thr_event = |(hot[1:0] & source_reg[fps_pkg::VR_LSB-1:fps_pkg::THR_LSB]);

    ////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        interval_next = interval_reg;
        source_next = source_reg;
        ovr_en_next = ovr_en_reg;
        pol_next = pol_reg;
        lock_en_next = lock_en_reg;
        lock_act_next = lock_act_reg;
        ovr_duty_next = ovr_duty_reg;
        rdata_next = rdata_reg;
        if (wr_int) begin
            interval_next = reg_wdata_i;
        end
        if (wr_src) begin
            source_next = reg_wdata_i;
        end
        if (wr_ovr) begin
            ovr_en_next = reg_wdata_i[fps_pkg::OVR_EN_BIT];
            pol_next = reg_wdata_i[fps_pkg::POL_BIT];
            lock_en_next = reg_wdata_i[fps_pkg::LOCK_EN_BIT];
            ovr_duty_next = reg_wdata_i[7:fps_pkg::OVR_DUTY_LSB];
            // Lock flag clears only by writing zero
            if (!reg_wdata_i[fps_pkg::LOCK_ACT_BIT]) begin
                lock_act_next = 1'b0;
            end
        end
        // Set wins over a same-cycle clear
        if (lock_en_reg && bound_thr_event) begin
            lock_act_next = 1'b1;
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                fps_pkg::ADDR_INTERVAL: rdata_next = interval_reg;
                fps_pkg::ADDR_SOURCE: rdata_next = source_reg;
                // Duty field reads back the duty in use
                fps_pkg::ADDR_OVERRIDE: rdata_next = {duty_reg, lock_act_reg,
                                                      lock_en_reg, pol_reg, ovr_en_reg};
                default: rdata_next = 8'h00_00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            interval_reg <= fps_pkg::RST_INTERVAL;
            source_reg <= fps_pkg::RST_SOURCE;
            ovr_en_reg <= fps_pkg::RST_OVERRIDE[fps_pkg::OVR_EN_BIT];
            pol_reg <= fps_pkg::RST_OVERRIDE[fps_pkg::POL_BIT];
            lock_en_reg <= fps_pkg::RST_OVERRIDE[fps_pkg::LOCK_EN_BIT];
            lock_act_reg <= fps_pkg::RST_OVERRIDE[fps_pkg::LOCK_ACT_BIT];
            ovr_duty_reg <= fps_pkg::RST_OVERRIDE[7:fps_pkg::OVR_DUTY_LSB];
            rdata_reg <= 8'h00_00;
        end else begin
            interval_reg <= interval_next;
            source_reg <= source_next;
            ovr_en_reg <= ovr_en_next;
            pol_reg <= pol_next;
            lock_en_reg <= lock_en_next;
            lock_act_reg <= lock_act_next;
            ovr_duty_reg <= ovr_duty_next;
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Ramp request for hot inputs: one duty step per ramp tick
    logic [31:0] ramp_div_reg, ramp_div_next;
    logic [3:0] ramp_reg, ramp_next;
    logic ramp_tick;

    assign ramp_tick = (ramp_div_reg == 32'(RAMP_CYC - 1));

    always_comb begin
        ramp_div_next = ramp_tick ? 32'h0000_0000 : ramp_div_reg + 32'h0000_0001;
        ramp_next = ramp_reg;
        if (ramp_tick) begin
            if (bound_hot && ramp_reg != fps_pkg::DUTY_FULL) begin
                ramp_next = ramp_reg + 4'h1;
            end else if (!bound_hot && ramp_reg != fps_pkg::DUTY_ZERO) begin
                ramp_next = ramp_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ramp_div_reg <= 32'h0000_0000;
            ramp_reg <= fps_pkg::DUTY_ZERO;
        end else begin
            ramp_div_reg <= ramp_div_next;
            ramp_reg <= ramp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Duty select and PWM
    logic [7:0] pwm_div_reg, pwm_div_next;
    logic [3:0] pwm_cnt_reg, pwm_cnt_next;
    logic out_reg, out_next;
    logic pwm_tick;

    assign pwm_tick = (pwm_div_reg == 8'(PWM_TICK_CYC - 1));

    always_comb begin
        duty_calc = fps_pkg::DUTY_ZERO;
        for (int z = 0; z < 4; z++) begin
            if (source_reg[fps_pkg::ZONE_LSB + z]) begin
                duty_calc = max4(duty_calc, zone_duty_i[4*z +: 4]);
            end
        end
        if (|source_reg[7:fps_pkg::THR_LSB]) begin
            duty_calc = max4(duty_calc, ramp_reg);
        end
        duty_next = duty_calc;
        if (ovr_en_reg) begin
            duty_next = ovr_duty_reg;
        end
        if (lock_act_reg) begin
            duty_next = fps_pkg::DUTY_FULL;
        end
        pwm_div_next = pwm_tick ? 8'h00 : pwm_div_reg + 8'h01;
        pwm_cnt_next = pwm_cnt_reg;
        if (pwm_tick) begin
            pwm_cnt_next = (pwm_cnt_reg == 4'(fps_pkg::PWM_STEPS - 1)) ? 4'h0 : pwm_cnt_reg + 4'h1;
        end
        out_next = (pwm_cnt_reg < duty_reg) ^ pol_reg;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            duty_reg <= fps_pkg::DUTY_ZERO;
            pwm_div_reg <= 8'h00;
            pwm_cnt_reg <= 4'h0;
            out_reg <= 1'b0;
        end else begin
            duty_reg <= duty_next;
            pwm_div_reg <= pwm_div_next;
            pwm_cnt_reg <= pwm_cnt_next;
            out_reg <= out_next;
        end
    end
    assign fan_drive_out_one_o = out_reg;

    ////////////////////////////////////////////////////////////////////
    // Throttle measurement: asserted samples over 256 << code samples
    logic [31:0] samp_div_reg, samp_div_next;
    logic samp_tick;
    logic [7:0] result [2];

    assign samp_tick = (samp_div_reg == 32'(SAMPLE_CYC - 1));
    assign samp_div_next = samp_tick ? 32'h0000_0000 : samp_div_reg + 32'h0000_0001;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            samp_div_reg <= 32'h0000_0000;
        end else begin
            samp_div_reg <= samp_div_next;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_meas
        logic [17:0] nsamp_reg, nsamp_next, hits_reg, hits_next, hits_sum, sh;
        logic [7:0] res_reg, res_next;
        logic [3:0] code, code_new;
        logic restart;

        assign code = clamp_code(interval_reg[4*ch +: 4]);
        assign code_new = reg_wdata_i[4*ch +: 4];
        // A changed period abandons the window in flight
        assign restart = wr_int && (code_new != interval_reg[4*ch +: 4]);

        always_comb begin
            nsamp_next = nsamp_reg;
            hits_next = hits_reg;
            res_next = res_reg;
            hits_sum = hits_reg + 18'(hot[ch]);
            sh = hits_sum >> code;
            if (restart) begin
                nsamp_next = 18'h0_0000;
                hits_next = 18'h0_0000;
            end else if (samp_tick) begin
                if (nsamp_reg + 18'h0_0001 ==
                    18'(fps_pkg::SAMPLES_PER_BASE) << code) begin
                    res_next = (sh > 18'(fps_pkg::RESULT_MAX)) ? fps_pkg::RESULT_MAX
                                                               : sh[7:0];
                    nsamp_next = 18'h0_0000;
                    hits_next = 18'h0_0000;
                end else begin
                    nsamp_next = nsamp_reg + 18'h0_0001;
                    hits_next = hits_sum;
                end
            end
        end

        always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                nsamp_reg <= 18'h0_0000;
                hits_reg <= 18'h0_0000;
                res_reg <= 8'h00;
            end else begin
                nsamp_reg <= nsamp_next;
                hits_reg <= hits_next;
                res_reg <= res_next;
            end
        end
        assign result[ch] = res_reg;
    end

    assign throttle_measure_result_one_o = result[0];
    assign throttle_measure_result_two_o = result[1];

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_int_write;
        wr_int |=> interval_reg == $past(reg_wdata_i);
    endproperty
    a_int_write: assert property (p_int_write) else $error("interval write lost");

    property p_thr2_code;
        samp_tick && g_meas[1].nsamp_reg + 18'h0_0001 == 18'(fps_pkg::SAMPLES_PER_BASE)
            << interval_reg[7:4] |=> g_meas[1].nsamp_reg == 18'h0_0000;
    endproperty
    a_thr2_code: assert property (p_thr2_code) else $error("channel two code wrong");

    property p_restart;
        g_meas[0].restart |=> g_meas[0].nsamp_reg == 18'h0_0000;
    endproperty
    a_restart: assert property (p_restart) else $error("window not restarted");

    property p_zone_max;
        !ovr_en_reg && !lock_act_reg && source_reg == 8'h00_01
            |=> duty_reg == $past(zone_duty_i[3:0]);
    endproperty
    a_zone_max: assert property (p_zone_max) else $error("zone duty not used");

    property p_ramp_up;
        ramp_tick && bound_hot && ramp_reg != fps_pkg::DUTY_FULL
            |=> ramp_reg == $past(ramp_reg) + 4'h1;
    endproperty
    a_ramp_up: assert property (p_ramp_up) else $error("ramp did not rise");

    property p_largest;
        !ovr_en_reg && !lock_act_reg |=> duty_reg >= $past(ramp_reg)
            || $past(source_reg[7:4]) == 4'h0;
    endproperty
    a_largest: assert property (p_largest) else $error("not largest request");

    property p_override;
        ovr_en_reg && !lock_act_reg && !wr_ovr |=> duty_reg == $past(ovr_duty_reg);
    endproperty
    a_override: assert property (p_override) else $error("override ignored");

    property p_polarity;
        duty_reg == fps_pkg::DUTY_FULL && $stable(duty_reg) && $stable(pol_reg)
            |=> fan_drive_out_one_o == !$past(pol_reg);
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");

    c_lock: cover property (lock_en_reg && bound_thr_event ##1 lock_act_reg);
    c_result: cover property (g_meas[0].res_reg != 8'h00);
    c_override: cover property (ovr_en_reg ##1 duty_reg == ovr_duty_reg);
endmodule

// ===== core/fps_pkg.sv
/*
 * Constants for the fan source-select and throttle-monitor slice.
 * Assumes a 50 MHz core clock and an 8-bit register access port.
 */
package fps_pkg;
    localparam logic [7:0] ADDR_INTERVAL = 8'h00_c7;
    localparam logic [7:0] ADDR_SOURCE = 8'h00_c8;
    localparam logic [7:0] ADDR_OVERRIDE = 8'h00_c9;
    localparam logic [7:0] RST_INTERVAL = 8'h00_11;
    localparam logic [7:0] RST_SOURCE = 8'h00_0f;
    localparam logic [7:0] RST_OVERRIDE = 8'h00_00;
    // Override control field positions
    localparam int OVR_EN_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int LOCK_EN_BIT = 2;
    localparam int LOCK_ACT_BIT = 3;
    localparam int OVR_DUTY_LSB = 4;
    // Source-select field positions
    localparam int ZONE_LSB = 0;
    localparam int THR_LSB = 4;
    localparam int VR_LSB = 6;
    // Interval field positions and code range
    localparam int THR1_TI_LSB = 0;
    localparam int THR2_TI_LSB = 4;
    localparam logic [3:0] TI_CODE_MAX = 4'h9;
    localparam logic [3:0] DUTY_FULL = 4'hf;
    localparam logic [3:0] DUTY_ZERO = 4'h0;
    localparam logic [7:0] RESULT_MAX = 8'hff;
    // Timing
    localparam real CLK_HZ = 50.0e6;
    localparam real BASE_INTERVAL_S = 0.73;
    localparam int SAMPLES_PER_BASE = 256;
    localparam int SAMPLE_CYCLES = $rtoi(BASE_INTERVAL_S * CLK_HZ / SAMPLES_PER_BASE);
    localparam real RAMP_STEP_S = 0.01;
    localparam int RAMP_CYCLES = $rtoi(RAMP_STEP_S * CLK_HZ);
    localparam real PWM_HZ = 22500.0;
    localparam int PWM_STEPS = 15;
    localparam int PWM_TICK_CYCLES = $rtoi(CLK_HZ / (PWM_HZ * PWM_STEPS));
endpackage

// ===== tb/fps_fan_source_tb.sv
/*
 * Self-checking bench for the fan source-select slice.
 * Assumes shortened sample, ramp and PWM tick counts; the partner drives pins.
 */
`timescale 1ns/1ns
module fps_fan_source_tb;
    localparam int SMP = 4;
    localparam int RMP = 3;
    localparam int TCK = 2;
    localparam int FRAME = 15 * TCK;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h0000;
    logic [15:0] zone_duty_i = 16'h0000;
    logic [3:0] hot_req = 4'h0;
    logic [7:0] reg_rdata_o, res_one, res_two, rdat, v;
    logic fan_drive_out_one_o, thr_one_n, thr_two_n, hot_a_n, hot_b_n;
    int high_count, src, d, z;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] raddr[4] = '{8'h00c7, 8'h00c8, 8'h00c9, 8'h00c6};
    logic [7:0] rexp[4] = '{8'h0011, 8'h000f, 8'h0000, 8'h0000};

    fps_fan_source #(.SAMPLE_CYC(SMP), .RAMP_CYC(RMP), .PWM_TICK_CYC(TCK)) fps_fan_source_i (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .zone_duty_i(zone_duty_i),
        .cpu_throttle_pin_one_n_i(thr_one_n), .cpu_throttle_pin_two_n_i(thr_two_n),
        .regulator_hot_in_a_n_i(hot_a_n), .regulator_hot_in_b_n_i(hot_b_n),
        .fan_drive_out_one_o(fan_drive_out_one_o),
        .throttle_measure_result_one_o(res_one), .throttle_measure_result_two_o(res_two));
    fps_partner #(.FRAME(FRAME)) fps_partner_i (
        .core_clk_i(core_clk_i), .hot_req_i(hot_req), .fan_drive_out_one_i(fan_drive_out_one_o),
        .cpu_throttle_pin_one_n_o(thr_one_n), .cpu_throttle_pin_two_n_o(thr_two_n),
        .regulator_hot_in_a_n_o(hot_a_n), .regulator_hot_in_b_n_o(hot_b_n),
        .high_count_o(high_count));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= dat;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        dat = reg_rdata_o;
    endtask

    // Largest lookup request among bound zones
    function automatic int zone_max(input int s, input logic [15:0] zd);
        int m = 0;
        for (int i = 0; i < 4; i++) begin
            if (s[i] && int'(zd[4*i +: 4]) > m) m = int'(zd[4*i +: 4]);
        end
        return m;
    endfunction

    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h35a8_8eee));
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd(raddr[k], rdat);
            check("reset_or_unmapped", rdat, rexp[k]);
        end
        for (int k = 0; k < 10; k++) begin
            src = (k < 4) ? (1 << k) : int'($urandom & 32'h0000_000f);
            @(posedge core_clk_i);
            zone_duty_i <= 16'($urandom);
            wr(fps_pkg::ADDR_SOURCE, 8'(src));
            tick(2 * FRAME + 4);
            d = zone_max(src, zone_duty_i);
            rd(fps_pkg::ADDR_SOURCE, rdat);
            check("source", rdat, 8'(src));
            rd(fps_pkg::ADDR_OVERRIDE, rdat);
            check("zone_duty", rdat, 8'(d << 4));
            check("fan_high", 8'(high_count), 8'(d * TCK));
        end
        for (int p = 0; p < 2; p++) begin
            d = int'($urandom_range(15, 0));
            v = 8'(d << 4) | 8'(p << 1) | 8'h0001;
            wr(fps_pkg::ADDR_OVERRIDE, v);
            tick(2 * FRAME + 4);
            rd(fps_pkg::ADDR_OVERRIDE, rdat);
            check("override", rdat, v);
            check("fan_pol", 8'(high_count), 8'(p ? FRAME - d * TCK : d * TCK));
        end
        wr(fps_pkg::ADDR_OVERRIDE, 8'h0000);
        for (int b = 0; b < 4; b++) begin
            z = int'($urandom_range(14, 1));
            @(posedge core_clk_i);
            zone_duty_i <= 16'(z);
            wr(fps_pkg::ADDR_SOURCE, 8'(8'h0010 << b) | 8'h0001);
            @(posedge core_clk_i);
            hot_req <= 4'(1 << b);
            tick(16 * RMP + 2 * FRAME);
            rd(fps_pkg::ADDR_OVERRIDE, rdat);
            check("ramp_up", rdat, 8'h00f0);
            check("fan_full", 8'(high_count), 8'(FRAME));
            @(posedge core_clk_i);
            hot_req <= 4'h0;
            tick(16 * RMP + 2 * FRAME);
            rd(fps_pkg::ADDR_OVERRIDE, rdat);
            check("ramp_down", rdat, 8'(z << 4));
        end
        // Bound throttle event pins full duty until the flag is written to zero
        wr(fps_pkg::ADDR_SOURCE, 8'h0010);
        wr(fps_pkg::ADDR_OVERRIDE, 8'h0004);
        @(posedge core_clk_i);
        hot_req <= 4'h1;
        tick(3);
        rd(fps_pkg::ADDR_OVERRIDE, rdat);
        check("lock_set", rdat, 8'h00fc);
        @(posedge core_clk_i);
        hot_req <= 4'h0;
        wr(fps_pkg::ADDR_OVERRIDE, 8'h0004);
        tick(16 * RMP);
        rd(fps_pkg::ADDR_OVERRIDE, rdat);
        check("lock_clear", rdat, 8'h0004);
        // One-cycle event lands with the clearing write: the set must win
        @(posedge core_clk_i);
        reg_addr_i <= fps_pkg::ADDR_OVERRIDE;
        reg_wdata_i <= 8'h0004;
        reg_wr_i <= 1'b1;
        hot_req <= 4'h1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        hot_req <= 4'h0;
        tick(2);
        rd(fps_pkg::ADDR_OVERRIDE, rdat);
        check("lock_set_wins", rdat, 8'h00fc);
        wr(fps_pkg::ADDR_OVERRIDE, 8'h0000);
        // Pins idle while the interval is first rewritten; both pins asserted for the second rewrite
        wr(fps_pkg::ADDR_INTERVAL, 8'h0000);
        tick(1024 + 8 * SMP);
        check("idle_one", res_one, 8'h0000);
        check("idle_two", res_two, 8'h0000);
        @(posedge core_clk_i);
        hot_req <= 4'h3;
        wr(fps_pkg::ADDR_INTERVAL, 8'h0021);
        rd(fps_pkg::ADDR_INTERVAL, rdat);
        check("interval", rdat, 8'h0021);
        tick(2048 - 8 * SMP);
        check("early_one", res_one, 8'h0000);
        tick(16 * SMP);
        check("late_one", res_one, 8'h00ff);
        check("early_two", res_two, 8'h0000);
        tick(2048);
        check("late_two", res_two, 8'h00ff);
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule

// ===== tb/fps_partner.sv
/*
 * Far-side model: throttle and regulator-hot pins, plus a fan that counts
 * drive-high clocks over each frame.
 * Assumes the bench commands the pins and the frame length matches the PWM.
 */
`timescale 1ns/1ns
module fps_partner #(
    parameter int FRAME = 30
) (
    input wire logic core_clk_i,
    input wire logic [3:0] hot_req_i,
    input wire logic fan_drive_out_one_i,
    output logic cpu_throttle_pin_one_n_o,
    output logic cpu_throttle_pin_two_n_o,
    output logic regulator_hot_in_a_n_o,
    output logic regulator_hot_in_b_n_o,
    output int high_count_o
);
    int cnt = 0;
    int acc = 0;
    int fan;
    int hc_reg = 0;
    ////////////////////////////////////////////////////////////////////////
    // Pins are active low and idle high
    assign cpu_throttle_pin_one_n_o = ~hot_req_i[0];
    assign cpu_throttle_pin_two_n_o = ~hot_req_i[1];
    assign regulator_hot_in_a_n_o = ~hot_req_i[2];
    assign regulator_hot_in_b_n_o = ~hot_req_i[3];
    ////////////////////////////////////////////////////////////////////////
    // Any window of one frame length sees the same count once duty is steady
    assign fan = (fan_drive_out_one_i === 1'b1) ? 1 : 0;
    assign high_count_o = hc_reg;
    always @(posedge core_clk_i) begin
        if (cnt == FRAME - 1) begin
            hc_reg <= acc + fan;
            acc <= 0;
            cnt <= 0;
        end else begin
            acc <= acc + fan;
            cnt <= cnt + 1;
        end
    end
endmodule
